/* File: dv/ulbap_arbiter_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module ulbap_arbiter_sva #(
   parameter int LED_HOLD_CYCLES = 20
) (
   input wire logic                          i_clk,
   input wire logic                          i_resetn,
   input wire logic [ulbap_pkg::BUS_N-1:0]   i_vme_request,
   input wire logic [ulbap_pkg::BUS_N-1:0]   i_dsp_request,
   input wire logic [ulbap_pkg::BUS_N-1:0]   o_bus_grant,
   input wire logic [ulbap_pkg::BUS_N-1:0]   o_vme_grant,
   input wire logic [ulbap_pkg::BUS_N-1:0]   o_dsp_grant,
   input wire logic [5:0]                    o_bus_owner,
   input wire logic                          o_dsp_bus_owned,
   input wire ulbap_pkg::ulbap_memctl_s      o_mem_ctl,
   input wire logic                          i_user_configured,
   input wire logic [ulbap_pkg::LED_N-1:0]   i_front_led_drive,
   input wire logic [ulbap_pkg::LED_N-1:0]   o_front_led
);
   import ulbap_pkg::*;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // ==========================================================
   // Arbitration
   // ==========================================================
   a_bus_exclusive: assert property (
      $onehot0({o_vme_grant[0], o_bus_grant[0], o_dsp_grant[0]}) &&
      $onehot0({o_vme_grant[1], o_bus_grant[1], o_dsp_grant[1]}) &&
      $onehot0({o_vme_grant[2], o_bus_grant[2], o_dsp_grant[2]}))
      else $error("bus granted to two masters");
   a_first_come: assert property (
      i_vme_request[0] && o_bus_owner[1:0] == 2'h0 |=> o_vme_grant[0])
      else $error("free bus not granted");
   a_grant_kept: assert property (
      o_vme_grant[1] && i_vme_request[1] |=> o_vme_grant[1])
      else $error("grant dropped while requested");
   a_release_frees: assert property (
      o_dsp_grant[1] && !i_dsp_request[1] |=> !o_dsp_grant[1] && o_bus_owner[3:2] == 2'h0)
      else $error("bus not freed on release");
   a_owner_user: assert property (
      o_bus_grant[BUS_A] |-> o_bus_owner[1:0] == 2'h2)
      else $error("owner differs from grant");
   a_x_with_a: assert property (
      $rose(o_bus_grant[BUS_A]) |-> ##[0:2] o_bus_grant[BUS_X])
      else $error("bus x not held with bus a");
   a_dsp_bus_kept: assert property (
      o_dsp_bus_owned)
      else $error("dsp bus lost");
   a_ce_needs_grant: assert property (
      !o_mem_ctl.ce_n[CE_RAM_A] |-> $past(o_bus_grant[BUS_A]))
      else $error("bank a enabled without grant");
   // ==========================================================
   // LEDs
   // ==========================================================
   a_unconfig_leds: assert property (
      !i_user_configured [*6] |-> o_front_led == 3'h7)
      else $error("leds not lit while unconfigured");
   a_pulse_lights: assert property (
      i_front_led_drive[0] [*2] |-> ##[1:6] o_front_led[0])
      else $error("short pulse not shown");
   c_vme: cover property (o_vme_grant[0]);
   c_read: cover property (o_bus_grant[0] && !o_mem_ctl.ce_n[0]);
   c_led: cover property ($fell(o_front_led[0]));
endmodule
bind ulbap_arbiter ulbap_arbiter_sva #(.LED_HOLD_CYCLES(LED_HOLD_CYCLES)) sva_u (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_vme_request(i_vme_request),
   .i_dsp_request(i_dsp_request), .o_bus_grant(o_bus_grant), .o_vme_grant(o_vme_grant),
   .o_dsp_grant(o_dsp_grant), .o_bus_owner(o_bus_owner), .o_dsp_bus_owned(o_dsp_bus_owned),
   .o_mem_ctl(o_mem_ctl), .i_user_configured(i_user_configured),
   .i_front_led_drive(i_front_led_drive), .o_front_led(o_front_led));
`default_nettype wire

/* File: dv/ulbap_arbiter_test.sv */
`timescale 1ns/10ps
`default_nettype none
module ulbap_arbiter_test;
   import ulbap_pkg::*;
   localparam int HOLD = 20;
   logic i_clk, i_resetn, cfg, dsp_own, oe_n, ok, rsel, inhibit, irq_fire, irq_line;
   logic [1:0] wr;
   logic [2:0] want, sel, vme_req, dsp_req, led_in, grant, vme_gnt, dsp_gnt, req_n, sel_n, led;
   logic [5:0] owner;
   logic [LADDR_W-1:0] addr, uaddr, mem_addr;
   logic [LDATA_W-1:0] udata, ctl_data, wdata;
   ulbap_memctl_s ctl;
   int errors, checks, cyc;

   ulbap_arbiter #(.LED_HOLD_CYCLES(HOLD)) dut_u (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_bus_request_n(req_n), .o_bus_grant(grant),
      .i_vme_request(vme_req), .o_vme_grant(vme_gnt), .i_dsp_request(dsp_req),
      .o_dsp_grant(dsp_gnt), .i_inhibit(inhibit), .o_bus_owner(owner),
      .o_dsp_bus_owned(dsp_own), .i_select_n(sel_n), .i_write_n(wr),
      .i_local_address_lines(uaddr), .i_local_data_lines(udata),
      .o_local_data_lines(ctl_data), .o_local_data_oe_n(oe_n), .o_mem_ctl(ctl),
      .o_mem_addr(mem_addr), .o_mem_wdata(wdata), .i_mem_a_rdata(32'h1234ABCD),
      .i_mem_b_rdata(32'h0F0F5AA5), .o_reg_select(rsel), .i_user_configured(cfg),
      .i_front_led_drive(led_in), .o_front_led(led));
   ulbap_user_model user_u (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_want(want), .i_sel_n(sel), .i_addr(addr),
      .i_grant(grant), .i_ctrl_oe_n(oe_n), .i_irq_fire(irq_fire), .o_request_n(req_n),
      .o_select_n(sel_n), .o_addr(uaddr), .o_data(udata),
      .o_dsp_external_irq_drive(irq_line));

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wait_gnt(input int b, input logic v, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < 12 && !hit; i++) begin
         @(negedge i_clk);
         hit = (grant[b] === v);
      end
   endtask
   task automatic results;
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset;
      chk("grant", 3'h0, grant);
      chk("leds", 3'h7, led);
      chk("dsp_own", 1'h1, dsp_own);
      chk("data_oe_n", 1'h1, oe_n);
   endtask
   task automatic t_vme_first;
      vme_req = 3'h1;
      @(negedge i_clk);
      chk("vme_gnt", 3'h1, vme_gnt);
      want = 3'h1;
      repeat (10) @(negedge i_clk);
      chk("user_a_denied", 1'h0, grant[BUS_A]);
      vme_req = 3'h0;
      wait_gnt(BUS_A, 1'b1, ok);
      chk("user_a_after", 1'h1, ok);
      want = 3'h0;
      wait_gnt(BUS_A, 1'b0, ok);
      chk("user_a_free", 1'h1, ok);
   endtask
   task automatic t_user_read;
      want = 3'h1;
      addr = 19'h2A5A5;
      wait_gnt(BUS_A, 1'b1, ok);
      chk("x_with_a", 1'h1, grant[BUS_X]);
      sel = 3'h6;
      repeat (8) @(negedge i_clk);
      chk("ce_a", 3'h6, ctl.ce_n);
      chk("oe_a", 1'h0, ctl.oe_n[0]);
      chk("ctl_drives", 1'h0, oe_n);
      chk("rdata", 32'h1234ABCD, ctl_data);
      chk("addr", 19'h2A5A5, mem_addr);
      sel = 3'h7;
      want = 3'h0;
      repeat (8) @(negedge i_clk);
      chk("ce_off", 3'h7, ctl.ce_n);
      chk("gnt_off", 3'h0, grant);
   endtask
   task automatic t_dsp;
      dsp_req = 3'h2;
      @(negedge i_clk);
      chk("dsp_gnt", 3'h2, dsp_gnt);
      chk("owner_b", 2'h3, owner[3:2]);
      want = 3'h2;
      repeat (10) @(negedge i_clk);
      chk("user_b_denied", 1'h0, grant[BUS_B]);
      dsp_req = 3'h0;
      wait_gnt(BUS_B, 1'b1, ok);
      chk("user_b_after", 1'h1, ok);
      want = 3'h0;
      repeat (8) @(negedge i_clk);
   endtask
   task automatic t_led;
      chk("leds_cfg", 3'h0, led);
      led_in = 3'h1;
      repeat (2) @(negedge i_clk);
      led_in = 3'h0;
      repeat (6) @(negedge i_clk);
      chk("led_on", 3'h1, led);
      repeat (HOLD - 6) @(negedge i_clk);
      chk("led_held", 3'h1, led);
      repeat (12) @(negedge i_clk);
      chk("led_off", 3'h0, led);
   endtask
   task automatic t_write;
      want = 3'h3;
      wait_gnt(BUS_B, 1'b1, ok);
      chk("gnt_ab", 1'h1, ok);
      sel = 3'h5;
      wr = 2'h1;
      repeat (6) @(negedge i_clk);
      chk("ce_b", 3'h5, ctl.ce_n);
      chk("we_b", 2'h1, ctl.we_n);
      chk("oe_off", 2'h3, ctl.oe_n);
      chk("wdata", 32'hC3A55A3C, wdata);
      sel = 3'h2;
      wr = 2'h2;
      repeat (6) @(negedge i_clk);
      chk("ce_flash", 3'h3, ctl.ce_n);
      chk("we_flash", 2'h2, ctl.we_n);
      sel = 3'h3;
      wr = 2'h3;
      repeat (6) @(negedge i_clk);
      chk("reg_sel", 1'h1, rsel);
      chk("ce_none", 3'h7, ctl.ce_n);
      sel = 3'h7;
      inhibit = 1'b1;
      @(negedge i_clk);
      chk("inhibit_free", 3'h0, grant);
      inhibit = 1'b0;
      want = 3'h0;
      repeat (8) @(negedge i_clk);
      chk("gnt_end", 3'h0, grant);
   endtask
   task automatic t_irq;
      irq_fire = 1'b1;
      @(negedge i_clk);
      irq_fire = 1'b0;
      chk("irq_low1", 1'h0, irq_line);
      @(negedge i_clk);
      chk("irq_low2", 1'h0, irq_line);
      @(negedge i_clk);
      chk("irq_high", 1'h1, irq_line);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         results();
      end
   end
   initial begin
      i_resetn = 1'b0;
      cfg = 1'b0;
      want = 3'h0;
      sel = 3'h7;
      vme_req = 3'h0;
      dsp_req = 3'h0;
      led_in = 3'h0;
      addr = 19'h00000;
      wr = 2'h3;
      inhibit = 1'b0;
      irq_fire = 1'b0;
      repeat (3) @(negedge i_clk);
      i_resetn = 1'b1;
      @(negedge i_clk);
      t_reset();
      cfg = 1'b1;
      repeat (8) @(negedge i_clk);
      t_led();
      t_vme_first();
      t_user_read();
      t_dsp();
      t_write();
      t_irq();
      results();
   end
endmodule
`default_nettype wire

/* File: dv/ulbap_user_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ulbap_user_model (
   input  wire logic                          i_clk,
   input  wire logic                          i_resetn,
   input  wire logic [ulbap_pkg::BUS_N-1:0]   i_want,
   input  wire logic [2:0]                    i_sel_n,
   input  wire logic [ulbap_pkg::LADDR_W-1:0] i_addr,
   input  wire logic [ulbap_pkg::BUS_N-1:0]   i_grant,
   input  wire logic                          i_ctrl_oe_n,
   input  wire logic                          i_irq_fire,
   output logic      [ulbap_pkg::BUS_N-1:0]   o_request_n,
   output logic      [2:0]                    o_select_n,
   output logic      [ulbap_pkg::LADDR_W-1:0] o_addr,
   output logic      [ulbap_pkg::LDATA_W-1:0] o_data,
   output logic                               o_dsp_external_irq_drive
);
   import ulbap_pkg::*;
   logic rel_ff;
   logic irq_ff;
   logic irq_cnt;
   // Interrupt line: low two cycles, then high at least two before the next pulse
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_ff  <= 1'b1;
         irq_cnt <= 1'b1;
      end else if (!irq_ff) begin
         irq_ff  <= irq_cnt;
         irq_cnt <= ~irq_cnt;
      end else if (i_irq_fire && irq_cnt) begin
         irq_ff  <= 1'b0;
         irq_cnt <= 1'b0;
      end else begin
         irq_cnt <= 1'b1;
      end
   end
   assign o_dsp_external_irq_drive = irq_ff;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rel_ff <= 1'b0;
      end else begin
         rel_ff <= ~rel_ff;
      end
   end
   assign o_request_n = i_resetn ? ~i_want : 3'h7;
   // A device is selected only while its bus is granted
   assign o_select_n = i_sel_n | ~i_grant;
   // Released lines toggle so a stale value never looks driven
   assign o_addr = i_grant[BUS_X] ? i_addr : {LADDR_W{rel_ff}};
   assign o_data = i_ctrl_oe_n ? 32'hC3A55A3C : {LDATA_W{~rel_ff}};
endmodule
`default_nettype wire

/* File: src/ulbap_arbiter.sv */
// Operation
// - Bus goes to first requester and stays until it withdraws or i_inhibit frees a user or DSP owner; others denied.
// - Three request lines (A, B, X), each with its own grant.
// - User requests active low, VME and DSP requests active high, grants active high.
// - Grants change only on the rising system clock edge.
// - A user request for bus A or B also requests bus X.
// - The DSP bus belongs permanently to the DSP, never arbitrated.
// - Valid select combinations route address/data and make OE, CE, WR.
// - LED drivers stretch pulses of two cycles to about 25 ms.
// - While user logic is unconfigured, all three LEDs are lit.
`timescale 1ns/10ps
`default_nettype none
module ulbap_arbiter
   import ulbap_pkg::*;
#(
   parameter int LED_HOLD_CYCLES = ulbap_pkg::LED_HOLD_CYC
) (
   input  wire logic                            i_clk,
   input  wire logic                            i_resetn,
   input  wire logic [ulbap_pkg::BUS_N-1:0]     i_bus_request_n,
   output logic      [ulbap_pkg::BUS_N-1:0]     o_bus_grant,
   input  wire logic [ulbap_pkg::BUS_N-1:0]     i_vme_request,
   output logic      [ulbap_pkg::BUS_N-1:0]     o_vme_grant,
   input  wire logic [ulbap_pkg::BUS_N-1:0]     i_dsp_request,
   output logic      [ulbap_pkg::BUS_N-1:0]     o_dsp_grant,
   input  wire logic                            i_inhibit,
   output logic      [5:0]                      o_bus_owner,
   output logic                                 o_dsp_bus_owned,
   input  wire logic [2:0]                      i_select_n,
   input  wire logic [1:0]                      i_write_n,
   input  wire logic [ulbap_pkg::LADDR_W-1:0]   i_local_address_lines,
   input  wire logic [ulbap_pkg::LDATA_W-1:0]   i_local_data_lines,
   output logic      [ulbap_pkg::LDATA_W-1:0]   o_local_data_lines,
   output logic                                 o_local_data_oe_n,
   output ulbap_pkg::ulbap_memctl_s             o_mem_ctl,
   output logic      [ulbap_pkg::LADDR_W-1:0]   o_mem_addr,
   output logic      [ulbap_pkg::LDATA_W-1:0]   o_mem_wdata,
   input  wire logic [ulbap_pkg::LDATA_W-1:0]   i_mem_a_rdata,
   input  wire logic [ulbap_pkg::LDATA_W-1:0]   i_mem_b_rdata,
   output logic                                 o_reg_select,
   input  wire logic                            i_user_configured,
   input  wire logic [ulbap_pkg::LED_N-1:0]     i_front_led_drive,
   output logic      [ulbap_pkg::LED_N-1:0]     o_front_led
);

   import ulbap_pkg::*;

   localparam logic [LED_CNT_W-1:0] LED_RELOAD = LED_CNT_W'(LED_HOLD_CYCLES);

   typedef struct packed {
      ulbap_owner_e [BUS_N-1:0]       owner;
      logic [BUS_N-1:0]               vme_gnt;
      logic [BUS_N-1:0]               user_gnt;
      logic [BUS_N-1:0]               dsp_gnt;
      ulbap_memctl_s                  memctl;
      logic [LADDR_W-1:0]             mem_addr;
      logic [LDATA_W-1:0]             mem_wdata;
      logic [LDATA_W-1:0]             ldata;
      logic                           ldata_oe_n;
      logic                           reg_sel;
      logic                           dsp_own;
      logic [LED_N-1:0]               led;
      logic [LED_N-1:0][LED_CNT_W-1:0] led_cnt;
   } ulbap_state_s;

   ulbap_state_s st_ff;
   ulbap_state_s nxt_st;
   ulbap_upins_s up;

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   ulbap_pin_sync #(
      .W   ($bits(ulbap_upins_s)),
      .RST (UPINS_RST)
   ) u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_d      ({i_bus_request_n, i_select_n, i_write_n, i_front_led_drive,
                  i_user_configured, i_local_address_lines, i_local_data_lines}),
      .o_q      (up)
   );

   function automatic logic [BUS_N-1:0] grants_of(input ulbap_owner_e [BUS_N-1:0] own,
                                                  input ulbap_owner_e who);
      logic [BUS_N-1:0] g;
      g = '0;
      for (int b = 0; b < BUS_N; b++) begin
         g[b] = (own[b] == who);
      end
      return g;
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      logic [BUS_N-1:0] ureq;
      logic [BUS_N-1:0] dreq;
      logic             ram_a;
      logic             ram_b;
      logic             flash;
      logic             rd_a;
      logic             rd_b;
      ureq   = '0;
      dreq   = '0;
      ram_a  = 1'b0;
      ram_b  = 1'b0;
      flash  = 1'b0;
      rd_a   = 1'b0;
      rd_b   = 1'b0;
      nxt_st = st_ff;

      // Arbitration: first come, held until withdrawn or, for user and DSP, inhibited
      ureq = ~up.req_n & {BUS_N{~i_inhibit}};
      ureq[BUS_X] = ureq[BUS_X] | ureq[BUS_A] | ureq[BUS_B];
      dreq = i_dsp_request & {BUS_N{~i_inhibit}};
      for (int b = 0; b < BUS_N; b++) begin
         case (st_ff.owner[b])
            OWN_FREE: begin
               if (i_vme_request[b]) begin
                  nxt_st.owner[b] = OWN_VME;
               end else if (ureq[b]) begin
                  nxt_st.owner[b] = OWN_USER;
               end else if (dreq[b]) begin
                  nxt_st.owner[b] = OWN_DSP;
               end
            end
            OWN_VME: begin
               if (!i_vme_request[b]) begin
                  nxt_st.owner[b] = OWN_FREE;
               end
            end
            OWN_USER: begin
               if (!ureq[b]) begin
                  nxt_st.owner[b] = OWN_FREE;
               end
            end
            OWN_DSP: begin
               if (!dreq[b]) begin
                  nxt_st.owner[b] = OWN_FREE;
               end
            end
            default: begin
               nxt_st.owner[b] = OWN_FREE;
            end
         endcase
      end
      nxt_st.vme_gnt  = grants_of(nxt_st.owner, OWN_VME);
      nxt_st.user_gnt = grants_of(nxt_st.owner, OWN_USER);
      nxt_st.dsp_gnt  = grants_of(nxt_st.owner, OWN_DSP);
      nxt_st.dsp_own  = 1'b1;

      // Routing of user accesses by select combination
      flash = ~up.sel_n[SEL_A] & ~up.sel_n[SEL_V] & st_ff.user_gnt[BUS_A];
      ram_a = ~up.sel_n[SEL_A] & up.sel_n[SEL_V] & st_ff.user_gnt[BUS_A];
      ram_b = ~up.sel_n[SEL_B] & ~(up.sel_n[SEL_A] & ~up.sel_n[SEL_V])
              & st_ff.user_gnt[BUS_B];
      rd_a  = (ram_a | flash) & up.wr_n[0];
      rd_b  = ram_b & up.wr_n[1];
      nxt_st.reg_sel = up.sel_n[SEL_A] & up.sel_n[SEL_B] & ~up.sel_n[SEL_V]
                       & st_ff.user_gnt[BUS_X];
      nxt_st.memctl.ce_n[CE_RAM_A] = ~ram_a;
      nxt_st.memctl.ce_n[CE_RAM_B] = ~ram_b;
      nxt_st.memctl.ce_n[CE_FLASH] = ~flash;
      nxt_st.memctl.oe_n = {~rd_b, ~rd_a};
      nxt_st.memctl.we_n = {~(ram_b & ~up.wr_n[1]), ~((ram_a | flash) & ~up.wr_n[0])};
      nxt_st.mem_addr  = st_ff.user_gnt[BUS_X] ? up.addr : ADDR_RST;
      nxt_st.mem_wdata = up.data;
      // Local data driven only for a single-source read toward the user
      nxt_st.ldata_oe_n = ~(rd_a ^ rd_b) | (ram_a & ram_b);
      nxt_st.ldata      = rd_b ? i_mem_b_rdata : i_mem_a_rdata;

      // LED stretchers
      for (int l = 0; l < LED_N; l++) begin
         if (up.led[l]) begin
            nxt_st.led_cnt[l] = LED_RELOAD;
         end else if (st_ff.led_cnt[l] != '0) begin
            nxt_st.led_cnt[l] = st_ff.led_cnt[l] - LED_CNT_W'(1);
         end
         nxt_st.led[l] = ~up.configured | up.led[l]
                         | (st_ff.led_cnt[l] != '0);
      end
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff.owner      <= '{default: OWN_FREE};
         st_ff.vme_gnt    <= 3'h0;
         st_ff.user_gnt   <= 3'h0;
         st_ff.dsp_gnt    <= 3'h0;
         st_ff.memctl     <= MEMCTL_RST;
         st_ff.mem_addr   <= ADDR_RST;
         st_ff.mem_wdata  <= DATA_RST;
         st_ff.ldata      <= DATA_RST;
         st_ff.ldata_oe_n <= 1'h1;
         st_ff.reg_sel    <= 1'h0;
         st_ff.dsp_own    <= 1'h1;
         st_ff.led        <= 3'h7;
         st_ff.led_cnt    <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign o_bus_grant        = st_ff.user_gnt;
   assign o_vme_grant        = st_ff.vme_gnt;
   assign o_dsp_grant        = st_ff.dsp_gnt;
   assign o_bus_owner        = st_ff.owner;
   assign o_dsp_bus_owned    = st_ff.dsp_own;
   assign o_local_data_lines = st_ff.ldata;
   assign o_local_data_oe_n  = st_ff.ldata_oe_n;
   assign o_mem_ctl          = st_ff.memctl;
   assign o_mem_addr         = st_ff.mem_addr;
   assign o_mem_wdata        = st_ff.mem_wdata;
   assign o_reg_select       = st_ff.reg_sel;
   assign o_front_led        = st_ff.led;

endmodule
`default_nettype wire

/* File: src/ulbap_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ulbap_pin_sync #(
   parameter int              W   = 1,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } ulbap_sync_s;

   ulbap_sync_s st_ff;
   ulbap_sync_s nxt_st;

   // ==========================================================
   // Three stages; a change counts once stages two and three agree
   // ==========================================================
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = i_d;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= '{s1: RST, s2: RST, s3: RST, q: RST};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_q = st_ff.q;

endmodule
`default_nettype wire

/* File: src/ulbap_pkg.sv */
package ulbap_pkg;

   // ==========================================================
   // Arbitrated buses and widths
   // ==========================================================
   localparam int BUS_N     = 3;
   localparam int BUS_A     = 0;
   localparam int BUS_B     = 1;
   localparam int BUS_X     = 2;
   localparam int LADDR_W   = 19;
   localparam int LDATA_W   = 32;
   localparam int LED_N     = 3;

   // ==========================================================
   // Device select positions (active low pins)
   // ==========================================================
   localparam int SEL_A     = 0;
   localparam int SEL_B     = 1;
   localparam int SEL_V     = 2;

   // Chip enable positions in the memory control group
   localparam int CE_RAM_A  = 0;
   localparam int CE_RAM_B  = 1;
   localparam int CE_FLASH  = 2;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 20;
   localparam int LED_HOLD_NS   = 25_000_000;
   localparam int LED_HOLD_CYC  = LED_HOLD_NS / CLK_PERIOD_NS;
   localparam int LED_CNT_W     = 21;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      OWN_FREE = 2'h0,
      OWN_VME  = 2'h1,
      OWN_USER = 2'h2,
      OWN_DSP  = 2'h3
   } ulbap_owner_e;

   typedef struct packed {
      logic [BUS_N-1:0]   req_n;
      logic [2:0]         sel_n;
      logic [1:0]         wr_n;
      logic [LED_N-1:0]   led;
      logic               configured;
      logic [LADDR_W-1:0] addr;
      logic [LDATA_W-1:0] data;
   } ulbap_upins_s;

   typedef struct packed {
      logic [2:0] ce_n;
      logic [1:0] oe_n;
      logic [1:0] we_n;
   } ulbap_memctl_s;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam ulbap_upins_s UPINS_RST = '{
      req_n: 3'h7, sel_n: 3'h7, wr_n: 2'h3, led: 3'h0, configured: 1'h0,
      addr: 19'h00000, data: 32'h00000000};
   localparam ulbap_memctl_s MEMCTL_RST = '{ce_n: 3'h7, oe_n: 2'h3, we_n: 2'h3};
   localparam logic [LDATA_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [LADDR_W-1:0] ADDR_RST = 19'h00000;

endpackage
